// ==== core/ivr_pkg.sv ====
// Package for the interrupt vector relocation block: APB offsets, field layout, timing and vector slots.
// Assumes a 40 MHz pclk and a 4K-word program memory with a 12-bit word address.
package ivr_pkg;

  localparam int unsigned PCLK_HZ = 40_000_000;
  localparam int unsigned PC_W = 12;

  // APB register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;

  // Control register fields
  localparam int unsigned CTRL_VCE_BIT = 0;
  localparam int unsigned CTRL_VTS_BIT = 1;
  localparam logic CTRL_VCE_RST = 1'h0;
  localparam logic CTRL_VTS_RST = 1'h0;

  // Status register fields
  localparam int unsigned STAT_BLOCK_BIT = 0;
  localparam int unsigned STAT_SUPP_BIT = 1;
  localparam int unsigned STAT_FUSE_BIT = 2;
  localparam int unsigned STAT_ALOCK_BIT = 3;
  localparam int unsigned STAT_BLOCK2_BIT = 4;
  localparam int unsigned STAT_INBOOT_BIT = 5;
  localparam int unsigned STAT_CNT_LSB = 8;

  // Change window length, counted in core clock cycles
  localparam int unsigned VCE_WINDOW_CYC = 4;
  localparam logic [2:0] VCE_CNT_LOAD = 3'(VCE_WINDOW_CYC - 1);

  // Program addresses
  localparam logic [PC_W-1:0] APP_RESET_ADDR = 12'h000;
  localparam logic [PC_W-1:0] BOOT_RESET_ADDR = 12'hC00;

  // Fixed vector slots relative to the table start
  localparam logic [4:0] SLOT_FIRST = 5'h01;
  localparam logic [4:0] SLOT_EXT_IRQ_0 = 5'h0A;
  localparam logic [4:0] SLOT_EXT_IRQ_3 = 5'h1C;
  localparam logic [4:0] SLOT_SELF_PROGRAM_READY = 5'h1F;

  typedef struct packed {
    logic vce;
    logic vts;
    logic [2:0] cnt;
    logic grant;
    logic pslverr;
    logic [31:0] prdata;
  } ivr_state_t;

  typedef struct packed {
    logic [PC_W-1:0] reset_addr;
    logic [PC_W-1:0] vector_addr;
  } ivr_vec_t;

endpackage : ivr_pkg

// ==== core/ivr_vector_calc.sv ====
// Registered reset address and vector address generator.
// Assumes the fuse is static and the request slot is held while a request is pending.
`timescale 1ns/1ps
`default_nettype none
module ivr_vector_calc (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic boot_reset_fuse,
  input wire logic vector_table_select,
  input wire logic [4:0] irq_slot,
  output ivr_pkg::ivr_vec_t vec
);

  function automatic logic [ivr_pkg::PC_W-1:0] table_base(input logic sel);
    table_base = sel ? ivr_pkg::BOOT_RESET_ADDR : ivr_pkg::APP_RESET_ADDR;
  endfunction : table_base

  ivr_pkg::ivr_vec_t vec_d;

  always_comb begin
    vec_d.reset_addr = boot_reset_fuse ? ivr_pkg::APP_RESET_ADDR : ivr_pkg::BOOT_RESET_ADDR;
    vec_d.vector_addr = table_base(vector_table_select) + {7'h00, irq_slot};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec <= '0;
    end else begin
      vec <= vec_d;
    end
  end

endmodule : ivr_vector_calc
`default_nettype wire

// ==== core/ivr_top.sv ====
// Interrupt vector relocation: APB control/status, timed change window, interrupt gating.
// Assumes an APB master on pclk and a core that presents requests, its fetch address and its I-flag.
//
// Behaviour
// - Vector select one places the table at the boot start address.
// - Fuse programmed starts at boot reset address; unprogrammed starts at 0x000.
// - First vector at 0x001, or boot address plus 0x001 when selected.
// - Each source uses its fixed slot offset from the table start.
// - Change enable clears after four cycles, or on a vector select write.
// - Change enable blocks interrupts for its four cycle window.
// - Window blocking never alters the core global interrupt enable flag.
// - Boot table plus application lock suppresses interrupts in application code.
// - Application table plus boot lock suppresses interrupts in boot code.
`timescale 1ns/1ps
`default_nettype none
module ivr_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic boot_reset_fuse,
  input wire logic app_section_lock_bit,
  input wire logic boot_section_lock_bit,
  input wire logic global_irq_enable,
  input wire logic [ivr_pkg::PC_W-1:0] exec_pc,
  input wire logic irq_req,
  input wire logic [4:0] irq_slot,
  output logic irq_grant,
  output logic [ivr_pkg::PC_W-1:0] irq_vector,
  output logic [ivr_pkg::PC_W-1:0] reset_addr,
  output logic vector_table_select,
  output logic irq_window_block
);

  ivr_pkg::ivr_state_t st_q;
  ivr_pkg::ivr_state_t st_d;
  ivr_pkg::ivr_vec_t vec;

  logic setup_ph;
  logic acc_wr;
  logic ctrl_sel;
  logic stat_sel;
  logic ctrl_wr;
  logic ce_set;
  logic in_boot;
  logic suppress;
  logic irq_ok;
  logic [31:0] stat_word;

  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = (a == ivr_pkg::CTRL_OFS) || (a == ivr_pkg::STAT_OFS);
  endfunction : addr_mapped

  assign setup_ph = psel && !penable;
  assign acc_wr = psel && penable && pwrite;
  assign ctrl_sel = paddr == ivr_pkg::CTRL_OFS;
  assign stat_sel = paddr == ivr_pkg::STAT_OFS;
  assign ctrl_wr = acc_wr && ctrl_sel;
  assign ce_set = ctrl_wr && !st_q.vce && pwdata[ivr_pkg::CTRL_VCE_BIT];

  assign in_boot = exec_pc >= ivr_pkg::BOOT_RESET_ADDR;
  // Lock bits are high when programmed
  assign suppress = (st_q.vts && app_section_lock_bit && !in_boot)
                 || (!st_q.vts && boot_section_lock_bit && in_boot);
  // The core flag is only read here, never written
  assign irq_ok = irq_req && global_irq_enable && !st_q.vce && !suppress;

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[ivr_pkg::STAT_BLOCK_BIT] = st_q.vce;
    stat_word[ivr_pkg::STAT_SUPP_BIT] = suppress;
    stat_word[ivr_pkg::STAT_FUSE_BIT] = boot_reset_fuse;
    stat_word[ivr_pkg::STAT_ALOCK_BIT] = app_section_lock_bit;
    stat_word[ivr_pkg::STAT_BLOCK2_BIT] = boot_section_lock_bit;
    stat_word[ivr_pkg::STAT_INBOOT_BIT] = in_boot;
    stat_word[ivr_pkg::STAT_CNT_LSB +: 3] = st_q.cnt;
  end

  always_comb begin
    st_d = st_q;
    // Change window countdown
    if (st_q.vce) begin
      if (st_q.cnt == 3'h0) begin
        st_d.vce = 1'b0;
      end else begin
        st_d.cnt = st_q.cnt - 3'h1;
      end
    end
    if (ctrl_wr) begin
      if (st_q.vce) begin
        st_d.vts = pwdata[ivr_pkg::CTRL_VTS_BIT];
        st_d.vce = 1'b0;
        st_d.cnt = 3'h0;
      end else if (pwdata[ivr_pkg::CTRL_VCE_BIT]) begin
        st_d.vce = 1'b1;
        st_d.cnt = ivr_pkg::VCE_CNT_LOAD;
      end
      // Select bit is kept when the window is closed
    end
    // Read data and error prepared in setup, presented in access
    if (setup_ph) begin
      st_d.pslverr = !addr_mapped(paddr);
      if (!pwrite && ctrl_sel) begin
        st_d.prdata = 32'h0000_0000;
        st_d.prdata[ivr_pkg::CTRL_VCE_BIT] = st_q.vce;
        st_d.prdata[ivr_pkg::CTRL_VTS_BIT] = st_q.vts;
      end else if (!pwrite && stat_sel) begin
        st_d.prdata = stat_word;
      end else begin
        st_d.prdata = 32'h0000_0000;
      end
    end
    st_d.grant = irq_ok;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{vce: ivr_pkg::CTRL_VCE_RST, vts: ivr_pkg::CTRL_VTS_RST, cnt: 3'h0, grant: 1'b0,
                pslverr: 1'b0, prdata: 32'h0000_0000};
    end else begin
      st_q <= st_d;
    end
  end

  ivr_vector_calc u_calc (
    .pclk(pclk),
    .presetn(presetn),
    .boot_reset_fuse(boot_reset_fuse),
    .vector_table_select(st_q.vts),
    .irq_slot(irq_slot),
    .vec(vec)
  );

  assign pready = 1'b1;
  assign prdata = st_q.prdata;
  assign pslverr = st_q.pslverr && psel && penable;
  assign irq_grant = st_q.grant;
  assign irq_vector = vec.vector_addr;
  assign reset_addr = vec.reset_addr;
  assign vector_table_select = st_q.vts;
  assign irq_window_block = st_q.vce;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_open;
    ce_set;
  endsequence

  sequence s_quiet_window;
    s_open ##1 (!ctrl_wr) [*4];
  endsequence

  sequence s_held_window;
    s_open ##1 (!ctrl_wr) [*3];
  endsequence

  a_window_holds: assert property (s_held_window |-> st_q.vce && !irq_grant)
    else $error("change window closed early");

  a_window_closes: assert property (s_quiet_window |=> !st_q.vce)
    else $error("change window stayed open past four cycles");

  a_select_taken: assert property (ctrl_wr && st_q.vce |=>
      st_q.vts == $past(pwdata[ivr_pkg::CTRL_VTS_BIT]) && !st_q.vce)
    else $error("select write in window not taken");

  a_select_locked: assert property (ctrl_wr && !st_q.vce |=> $stable(st_q.vts))
    else $error("select changed without open window");

  a_window_blocks: assert property (st_q.vce && irq_req |=> !irq_grant)
    else $error("interrupt granted during change window");

  a_flag_respected: assert property (irq_grant |-> $past(global_irq_enable) && $past(irq_req))
    else $error("grant without core enable");

  a_app_lock: assert property (st_q.vts && app_section_lock_bit && !in_boot |=> !irq_grant)
    else $error("interrupt in application code under lock");

  a_boot_lock: assert property (!st_q.vts && boot_section_lock_bit && in_boot |=> !irq_grant)
    else $error("interrupt in boot code under lock");

  a_vector_place: assert property (irq_grant |-> irq_vector ==
      ($past(st_q.vts) ? ivr_pkg::BOOT_RESET_ADDR : ivr_pkg::APP_RESET_ADDR) + {7'h00, $past(irq_slot)})
    else $error("vector address wrong");

  a_first_slot: assert property (irq_grant && $past(irq_slot) == ivr_pkg::SLOT_FIRST && !$past(st_q.vts)
      |-> irq_vector == 12'h001)
    else $error("first vector not at start plus one");

  a_slot_fixed: assert property (irq_grant && $past(irq_slot) == ivr_pkg::SLOT_SELF_PROGRAM_READY
      && !$past(st_q.vts) |-> irq_vector == 12'h01F)
    else $error("self programming slot misplaced");

  a_reset_place: assert property ($stable(boot_reset_fuse) |=> reset_addr ==
      ($past(boot_reset_fuse) ? ivr_pkg::APP_RESET_ADDR : ivr_pkg::BOOT_RESET_ADDR))
    else $error("reset address does not follow fuse");

  a_apb_unmapped: assert property (setup_ph && !addr_mapped(paddr) ##1 psel && penable |-> pslverr)
    else $error("unmapped access not flagged");

  sequence s_ctrl_read;
    setup_ph && !pwrite && ctrl_sel ##1 psel && penable;
  endsequence

  sequence s_stat_read;
    setup_ph && !pwrite && stat_sel ##1 psel && penable;
  endsequence

  sequence s_unmapped_read;
    setup_ph && !pwrite && !addr_mapped(paddr) ##1 psel && penable;
  endsequence

  sequence s_fuse_unprog;
    presetn && boot_reset_fuse ##1 boot_reset_fuse;
  endsequence

  sequence s_fuse_prog;
    presetn && !boot_reset_fuse ##1 !boot_reset_fuse;
  endsequence

  a_count_load: assert property (ce_set |=> st_q.vce && st_q.cnt == ivr_pkg::VCE_CNT_LOAD)
    else $error("change window not loaded on enable write");

  a_count_step: assert property (st_q.vce && st_q.cnt != 3'h0 && !ctrl_wr |=>
      st_q.vce && st_q.cnt == $past(st_q.cnt) - 3'h1)
    else $error("change window count did not step");

  a_count_expire: assert property (st_q.vce && st_q.cnt == 3'h0 && !ctrl_wr |=> !st_q.vce)
    else $error("change window did not expire");

  a_closed_count: assert property (!st_q.vce |-> st_q.cnt == 3'h0)
    else $error("count left running with window closed");

  a_open_only: assert property (!st_q.vce && !ce_set |=> !st_q.vce)
    else $error("window opened without enable write");

  a_select_hold: assert property (!(ctrl_wr && st_q.vce) |=> $stable(st_q.vts))
    else $error("select changed outside a window write");

  a_select_close: assert property (ctrl_wr && st_q.vce |=> st_q.cnt == 3'h0 && !irq_window_block)
    else $error("select write left window open");

  a_grant_needs: assert property (irq_grant |-> !$past(st_q.vce) && !$past(suppress))
    else $error("grant while blocked or suppressed");

  a_grant_given: assert property (irq_req && global_irq_enable && !st_q.vce && !suppress |=> irq_grant)
    else $error("allowed interrupt not granted");

  a_flag_gates: assert property (!global_irq_enable |=> !irq_grant)
    else $error("grant with core enable clear");

  a_vector_app: assert property (irq_grant && !$past(st_q.vts) |-> irq_vector == {7'h00, $past(irq_slot)})
    else $error("application table vector wrong");

  a_vector_boot: assert property (irq_grant && $past(st_q.vts) |->
      irq_vector == ivr_pkg::BOOT_RESET_ADDR + {7'h00, $past(irq_slot)})
    else $error("boot table vector wrong");

  a_boot_first: assert property (irq_grant && $past(irq_slot) == ivr_pkg::SLOT_FIRST && $past(st_q.vts)
      |-> irq_vector == ivr_pkg::BOOT_RESET_ADDR + 12'h001)
    else $error("first boot vector not at boot start plus one");

  a_ext0_slot: assert property (irq_grant && $past(irq_slot) == ivr_pkg::SLOT_EXT_IRQ_0
      |-> irq_vector[4:0] == ivr_pkg::SLOT_EXT_IRQ_0)
    else $error("external interrupt 0 slot misplaced");

  a_ext3_slot: assert property (irq_grant && $past(irq_slot) == ivr_pkg::SLOT_EXT_IRQ_3
      |-> irq_vector[4:0] == ivr_pkg::SLOT_EXT_IRQ_3)
    else $error("external interrupt 3 slot misplaced");

  a_spm_boot: assert property (irq_grant && $past(irq_slot) == ivr_pkg::SLOT_SELF_PROGRAM_READY && $past(st_q.vts)
      |-> irq_vector == ivr_pkg::BOOT_RESET_ADDR + 12'h01F)
    else $error("self programming slot misplaced in boot table");

  a_reset_unprog: assert property (s_fuse_unprog |-> reset_addr == ivr_pkg::APP_RESET_ADDR)
    else $error("unprogrammed fuse reset address wrong");

  a_reset_prog: assert property (s_fuse_prog |-> reset_addr == ivr_pkg::BOOT_RESET_ADDR)
    else $error("programmed fuse reset address wrong");

  a_ctrl_read: assert property (s_ctrl_read |-> prdata[ivr_pkg::CTRL_VCE_BIT] == $past(st_q.vce)
      && prdata[ivr_pkg::CTRL_VTS_BIT] == $past(st_q.vts) && !pslverr)
    else $error("control read data wrong");

  a_stat_read: assert property (s_stat_read |-> prdata[ivr_pkg::STAT_BLOCK_BIT] == $past(st_q.vce)
      && prdata[ivr_pkg::STAT_FUSE_BIT] == $past(boot_reset_fuse)
      && prdata[ivr_pkg::STAT_CNT_LSB +: 3] == $past(st_q.cnt))
    else $error("status read data wrong");

  a_unmapped_zero: assert property (s_unmapped_read |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");

endmodule : ivr_top
`default_nettype wire

// ==== tb/ivr_core_model.sv ====
// Core model: pending interrupt, its slot, fetch address and I-flag.
// Assumes the bench sets its wishes on pclk edges; outputs move after edges.
`timescale 1ns/1ps
`default_nettype none
module ivr_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic want_irq,
  input wire logic want_ie,
  input wire logic [4:0] want_slot,
  input wire logic [ivr_pkg::PC_W-1:0] want_pc,
  output logic irq_req,
  output logic [4:0] irq_slot,
  output logic [ivr_pkg::PC_W-1:0] exec_pc,
  output logic global_irq_enable
);
  // Slot means nothing without a request, so it toggles then
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req <= 1'b0;
      irq_slot <= 5'h00;
      exec_pc <= 12'h000;
      global_irq_enable <= 1'b0;
    end else begin
      irq_req <= want_irq;
      irq_slot <= want_irq ? want_slot : ~irq_slot;
      exec_pc <= want_pc;
      global_irq_enable <= want_ie;
    end
  end
endmodule : ivr_core_model
`default_nettype wire

// ==== tb/ivr_tb_top.sv ====
// Testbench: APB master, core model and self checks for ivr_top.
// Assumes zero-wait APB and registered grant and vector outputs.
`timescale 1ns/1ps
`default_nettype none
module ivr_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic fuse = 1'b1;
  logic alock = 1'b0;
  logic block = 1'b0;
  logic want_irq = 1'b0;
  logic want_ie = 1'b1;
  logic [4:0] want_slot = 5'h00;
  logic [11:0] want_pc = 12'h000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, ie, irq_req, irq_grant, sel, win;
  logic [4:0] slot, s;
  logic [11:0] pc, irq_vector, reset_addr;
  logic [4:0] slots [4] = '{5'h01, 5'h0A, 5'h1C, 5'h1F};
  int miscompares = 0;
  int tests_run = 0;
  int k, cnt, bad;
  always #12.5 pclk = ~pclk;
  ivr_core_model core (.pclk(pclk), .presetn(presetn), .want_irq(want_irq), .want_slot(want_slot),
    .want_pc(want_pc), .want_ie(want_ie), .irq_req(irq_req), .irq_slot(slot), .exec_pc(pc),
    .global_irq_enable(ie));
  ivr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .boot_reset_fuse(fuse), .app_section_lock_bit(alock), .boot_section_lock_bit(block),
    .global_irq_enable(ie), .exec_pc(pc), .irq_req(irq_req), .irq_slot(slot), .irq_grant(irq_grant),
    .irq_vector(irq_vector), .reset_addr(reset_addr), .vector_table_select(sel), .irq_window_block(win));
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      check(32'h0, 32'h1, "pready timeout");
      final_report();
    end
  endtask : apb
  function automatic logic [11:0] exp_vec(input logic vs, input logic [4:0] sl);
    return (vs ? ivr_pkg::BOOT_RESET_ADDR : ivr_pkg::APP_RESET_ADDR) + {7'h00, sl};
  endfunction : exp_vec
  task automatic irq_try(input logic [4:0] sl, input logic [11:0] p, input logic g, input logic [11:0] v);
    @(posedge pclk);
    want_irq <= 1'b1;
    want_slot <= sl;
    want_pc <= p;
    repeat (3) @(posedge pclk);
    #1;
    check({31'h0, irq_grant}, {31'h0, g}, "grant");
    if (g) check({20'h0, irq_vector}, {20'h0, v}, "vector");
    @(posedge pclk);
    want_irq <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : irq_try
  task automatic move(input logic vs);
    apb(1'b1, ivr_pkg::CTRL_OFS, 32'h1);
    apb(1'b1, ivr_pkg::CTRL_OFS, {30'h0, vs, 1'b0});
    #1;
    check({31'h0, sel}, {31'h0, vs}, "select");
    check({31'h0, win}, 32'h0, "window closed by select write");
    for (k = 0; k < 10; k++) begin
      s = (k < 4) ? slots[k] : 5'($urandom);
      irq_try(s, 12'h000, 1'b1, exp_vec(vs, s));
    end
  endtask : move
  initial begin
    k = $urandom(32'h779A71A9);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    check({20'h0, reset_addr}, 32'h0, "reset address unprogrammed");
    apb(1'b0, ivr_pkg::CTRL_OFS, 32'h0);
    check(rd, 32'h0, "control reset value");
    apb(1'b0, 12'h010, 32'h0);
    check({31'h0, err}, 32'h1, "unmapped error");
    fuse <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    check({20'h0, reset_addr}, {20'h0, ivr_pkg::BOOT_RESET_ADDR}, "reset address programmed");
    apb(1'b1, ivr_pkg::CTRL_OFS, 32'h2);
    #1;
    check({31'h0, sel}, 32'h0, "select without enable");
    @(posedge pclk);
    want_irq <= 1'b1;
    want_slot <= 5'h0A;
    repeat (3) @(posedge pclk);
    apb(1'b1, ivr_pkg::CTRL_OFS, 32'h1);
    #1;
    cnt = 0;
    bad = 0;
    for (k = 0; k < 8; k++) begin
      if (win === 1'b1) cnt++;
      if (k >= 1 && k <= 4 && irq_grant !== 1'b0) bad++;
      @(posedge pclk);
      #1;
    end
    check(cnt, 4, "window length");
    check(bad, 0, "grant inside window");
    check({31'h0, irq_grant}, 32'h1, "grant after window");
    @(posedge pclk);
    want_irq <= 1'b0;
    move(1'b1);
    alock <= 1'b1;
    irq_try(5'h0A, 12'h100, 1'b0, 12'h000);
    irq_try(5'h0A, 12'hC10, 1'b1, 12'hC0A);
    alock <= 1'b0;
    move(1'b0);
    block <= 1'b1;
    irq_try(5'h1C, 12'hC10, 1'b0, 12'h000);
    irq_try(5'h1C, 12'h100, 1'b1, 12'h01C);
    want_ie <= 1'b0;
    irq_try(5'h0A, 12'h100, 1'b0, 12'h000);
    want_ie <= 1'b1;
    want_pc <= 12'hC10;
    apb(1'b1, ivr_pkg::STAT_OFS, 32'h3);
    #1;
    check({30'h0, sel, win}, 32'h0, "status write ignored");
    apb(1'b0, ivr_pkg::STAT_OFS, 32'h0);
    check(rd, (32'h1 << ivr_pkg::STAT_SUPP_BIT) | (32'h1 << ivr_pkg::STAT_BLOCK2_BIT)
      | (32'h1 << ivr_pkg::STAT_INBOOT_BIT), "status word");
    final_report();
  end
endmodule : ivr_tb_top
`default_nettype wire
